// ===== card_reader_mode_control_test.sv
`timescale 1ns/1ps
module card_reader_mode_control_test
  import crmc_pkg::*;
;
  // ---------------------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------------------
  logic                   sys_clk     = 1'h0;
  logic                   rst         = 1'h1;
  logic                   ce          = 1'h1;
  logic                   strap_req   = 1'h1;
  logic                   mode_req    = 1'h0;
  crmc_status_type        status_req  = 8'h00;
  logic                   reg_wr      = 1'h0;
  logic                   reg_rd      = 1'h0;
  logic [CRMC_ADDR_W-1:0] reg_addr    = 4'h0;
  logic [CRMC_DATA_W-1:0] reg_wdata   = 8'h00;
  logic [CRMC_DATA_W-1:0] reg_rdata;
  logic                   mode_pin, i2c_sel_pin, sleeping, reader_sel, cfg_apply, irq_event;
  crmc_status_type        status_pin;
  crmc_path_type          path;
  int                     bad_count   = 0;
  int                     check_count = 0;
  int                     cycles      = 0;
  int                     apply_cnt   = 0;
  logic [31:0]            seed        = 32'h0000_0061;
  logic [7:0]             val [1:9];
  logic [7:0]             ctrl_tab [8] = '{8'h1A, 8'h1B, 8'h1F, 8'h1D, 8'h19, 8'h1B, 8'h0B, 8'h1A};
  logic                   mode_tab [8] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};

  // clock inversion every half period
  always #2 sys_clk = ~sys_clk;

  crmc_top #(
    .DUAL_SLOT    (1),
    .BREAK_CYCLES (2)
  ) crmc_top_inst (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .ce          (ce),
    .mode_pin    (mode_pin),
    .i2c_sel_pin (i2c_sel_pin),
    .status_pin  (status_pin),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_rdata   (reg_rdata),
    .path        (path),
    .sleeping    (sleeping),
    .reader_sel  (reader_sel),
    .cfg_apply   (cfg_apply),
    .irq_event   (irq_event)
  );

  crmc_host_model crmc_host_model_inst (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .strap_req   (strap_req),
    .mode_req    (mode_req),
    .status_req  (status_req),
    .i2c_sel_pin (i2c_sel_pin),
    .mode_pin    (mode_pin),
    .status_pin  (status_pin)
  );

  // ---------------------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // asleep when wakeup clear, mode line low or mode field inactive
  function automatic logic exp_sleep(input logic [7:0] c, input logic m);
    return !c[0] || !m || c[2:1] == 2'h0 || c[2:1] == 2'h3;
  endfunction : exp_sleep

  // host switches follow their bits, minus the card the reader owns
  function automatic logic [7:0] exp_host(input logic [7:0] c, input logic rd);
    logic [1:0] h;
    h = {c[4], c[3]};
    if (rd) begin
      h = h & (c[2] ? 2'h1 : 2'h2);
    end
    return {6'h00, h};
  endfunction : exp_host

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask : check_bit

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask : reg_write

  // data is looked at an extra edge later, as it holds until the next read
  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    @(posedge sys_clk);
    #1;
    check_byte(reg_rdata, exp);
  endtask : reg_read

  // lets a refused change show itself, then waits bounded for the target
  task automatic wait_state(input logic rd);
    repeat (12) @(posedge sys_clk);
    for (int n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      #1;
      if (path.usb_reader_close === rd && sleeping === !rd) break;
    end
  endtask : wait_state

  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    strap_req <= s;
    rst       <= 1'h1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : do_reset

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // deferred-action pulses and the hang limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cfg_apply === 1'h1) apply_cnt <= apply_cnt + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test;
    end
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    do_reset(1'h1);
    check_bit(sleeping, 1'h1);
    check_byte({6'h00, path.host_close}, exp_host(8'h18, 1'h0));
    check_bit(path.usb_host_close, 1'h1);
    reg_read(4'h0, 8'h18);
    $display("test defaults done");
    for (int i = 1; i < 10; i++) begin
      seed   = xorshift(seed);
      val[i] = seed[7:0];
      reg_write(i[3:0], seed[7:0]);
    end
    for (int i = 1; i < 10; i++) reg_read(i[3:0], val[i]);
    reg_write(4'hC, 8'h5A);
    reg_read(4'hC, 8'h00);
    repeat (4) begin
      @(posedge sys_clk);
      seed = xorshift(seed);
      status_req <= seed[7:0];
      repeat (4) @(posedge sys_clk);
      reg_read(CRMC_ADDR_STATUS, seed[7:0]);
      check_bit(irq_event, |(seed[7:0] & val[4]));
    end
    foreach (ctrl_tab[i]) begin
      if (i < 4) begin
        reg_write(4'h0, {3'h0, i[1:0], 3'h0});
        repeat (3) @(posedge sys_clk);
        #1;
        check_byte({6'h00, path.host_close}, exp_host({3'h0, i[1:0], 3'h0}, 1'h0));
      end
    end
    $display("test registers done");
    foreach (ctrl_tab[i]) begin
      @(posedge sys_clk);
      mode_req <= mode_tab[i];
      reg_write(4'h0, ctrl_tab[i]);
      wait_state(!exp_sleep(ctrl_tab[i], mode_tab[i]));
      check_bit(sleeping, exp_sleep(ctrl_tab[i], mode_tab[i]));
      check_bit(path.mcu_on, !exp_sleep(ctrl_tab[i], mode_tab[i]));
      check_byte({6'h00, path.host_close},
                 exp_host(ctrl_tab[i], !exp_sleep(ctrl_tab[i], mode_tab[i])));
      if (!exp_sleep(ctrl_tab[i], mode_tab[i])) check_bit(reader_sel, ctrl_tab[i][2]);
    end
    check_byte(apply_cnt[7:0], 8'h01);
    $display("test i2c modes done");
    do_reset(1'h0);
    reg_write(4'h0, 8'h1D);
    reg_read(4'h0, 8'h18);
    @(posedge sys_clk);
    mode_req   <= 1'h1;
    status_req <= 8'h00;
    wait_state(1'h1);
    check_bit(path.usb_reader_close, 1'h1);
    check_bit(reader_sel, 1'h0);
    @(posedge sys_clk);
    status_req <= 8'h04;
    repeat (5) @(posedge sys_clk);
    ce       <= 1'h0;
    mode_req <= 1'h0;
    #1;
    check_bit(irq_event, 1'h1);
    // clock enable low: the mode drop must not be followed while frozen
    repeat (10) @(posedge sys_clk);
    #1;
    check_bit(path.usb_reader_close, 1'h1);
    @(posedge sys_clk);
    ce <= 1'h1;
    wait_state(1'h0);
    check_bit(sleeping, 1'h1);
    $display("test simple control done");
    stop_test;
  end
endmodule : card_reader_mode_control_test

bind crmc_top crmc_top_assertions #(
  .DUAL_SLOT    (DUAL_SLOT),
  .BREAK_CYCLES (BREAK_CYCLES)
) crmc_top_assertions_inst (
  .sys_clk     (sys_clk),
  .rst         (rst),
  .mode_pin    (mode_pin),
  .i2c_sel_pin (i2c_sel_pin),
  .status_pin  (status_pin),
  .path        (path),
  .sleeping    (sleeping),
  .reader_sel  (reader_sel),
  .cfg_apply   (cfg_apply),
  .irq_event   (irq_event)
);

// ===== crmc_host_model.sv
`timescale 1ns/1ps
module crmc_host_model
  import crmc_pkg::*;
(
  input  wire logic            sys_clk,            // clock
  input  wire logic            rst,                // reset window
  input  wire logic            strap_req,          // wanted strap
  input  wire logic            mode_req,           // wanted mode
  input  wire crmc_status_type status_req,         // wanted status
  output logic                 i2c_sel_pin = 1'h1, // strap level
  output logic                 mode_pin    = 1'h0, // mode line
  output crmc_status_type      status_pin  = 8'h00 // status levels
);
  // strap may only move while the supply is coming up, i.e. in reset
  always @(posedge sys_clk) begin
    if (rst) begin
      i2c_sel_pin <= strap_req;
    end
    mode_pin   <= mode_req;
    status_pin <= status_req;
  end
endmodule : crmc_host_model

// ===== crmc_pkg.sv
//------------------------------------------------------------------------------
// Functional notes
// - pass-through: host card port reaches the card unchanged through closed switches.
// - card-reader: selected card goes to internal reader, host cut off.
// - simple control: the mode select level chooses pass-through or card-reader.
// - simple control: only card 1 can ever become the reader card.
// - two-port I2C: each card's host switches follow their own bit.
// - I2C master reads and writes internal registers through the register port.
// - control register holds wakeup, card select and switch bits; IE registers.
// - status reads show errors, detects, supplies, busy, update; I2C adds interrupts.
// - sleep always returns the device to pass-through.
// - switch bits for card 1 and 2 still act in pass-through.
// - reader-tied register writes stored at once, action deferred until reader.
// - I2C: sleep when wakeup clear, mode low or mode inactive; simple control: sleep when mode low; controller off.
// - control register resets to 0x18: switches closed, inactive, asleep.
//------------------------------------------------------------------------------
package crmc_pkg;

  // ---------------------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------------------
  localparam int unsigned CRMC_ADDR_W       = 4;
  localparam int unsigned CRMC_DATA_W       = 8;
  localparam logic [3:0]  CRMC_ADDR_CONTROL = 4'h0;
  localparam logic [3:0]  CRMC_ADDR_CFG_LO  = 4'h1;
  localparam logic [3:0]  CRMC_ADDR_IE1     = 4'h4;
  localparam logic [3:0]  CRMC_ADDR_IE2     = 4'h5;
  localparam logic [3:0]  CRMC_ADDR_CFG_HI  = 4'h9;
  localparam logic [3:0]  CRMC_ADDR_STATUS  = 4'hA;
  localparam logic [7:0]  CRMC_CONTROL_RST  = 8'h18;
  localparam logic [7:0]  CRMC_CFG_RST      = 8'h00;
  localparam logic [7:0]  CRMC_UNMAPPED_RD  = 8'h00;

  // ---------------------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CRMC_BIT_WAKEUP  = 0;
  localparam int unsigned CRMC_BIT_MODE_LO = 1;
  localparam int unsigned CRMC_BIT_SD1SW   = 3;
  localparam int unsigned CRMC_BIT_SD2SW   = 4;
  localparam logic [1:0]  CRMC_MODE_OFF    = 2'h0;
  localparam logic [1:0]  CRMC_MODE_CARD1  = 2'h1;
  localparam logic [1:0]  CRMC_MODE_CARD2  = 2'h2;
  localparam logic [1:0]  CRMC_MODE_OFF2   = 2'h3;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CRMC_CLK_PERIOD_PS = 4000;
  localparam int unsigned CRMC_BREAK_NS      = 100;
  localparam int unsigned CRMC_BREAK_RAW     =
    (CRMC_BREAK_NS * 1000 + CRMC_CLK_PERIOD_PS - 1) / CRMC_CLK_PERIOD_PS;
  localparam int unsigned CRMC_BREAK_CYCLES  = (CRMC_BREAK_RAW < 1) ? 1 : CRMC_BREAK_RAW;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CRMC_ST_PASS,
    CRMC_ST_BREAK_IN,
    CRMC_ST_READER,
    CRMC_ST_BREAK_OUT
  } crmc_state_type;

  typedef struct packed {
    logic sd_err;
    logic vtm_ok;
    logic vsd_ok;
    logic vbus_ok;
    logic card2_det;
    logic card1_det;
    logic busy;
    logic fw_upd;
  } crmc_status_type;

  typedef struct packed {
    logic [1:0] host_close;
    logic [1:0] reader_close;
    logic       usb_host_close;
    logic       usb_reader_close;
    logic       mcu_on;
  } crmc_path_type;

endpackage : crmc_pkg

// ===== crmc_regfile.sv
`timescale 1ns/1ps
module crmc_regfile
  import crmc_pkg::*;
(
  input  wire logic                   sys_clk,  // system clock
  input  wire logic                   rst,      // synchronous reset
  input  wire logic                   ce,       // clock enable
  input  wire logic                   wr_en,    // write strobe, already gated
  input  wire logic                   rd_en,    // read strobe
  input  wire logic [CRMC_ADDR_W-1:0] addr,     // register index
  input  wire logic [CRMC_DATA_W-1:0] wdata,    // write data
  input  wire logic [CRMC_DATA_W-1:0] status,   // live status byte
  output logic      [CRMC_DATA_W-1:0] rdata,    // registered read data
  output logic      [CRMC_DATA_W-1:0] control,  // control byte
  output logic      [CRMC_DATA_W-1:0] ie_mask   // IE1 byte
);

  logic [CRMC_DATA_W-1:0] mem_reg [0:9];

  wire in_map = (addr <= CRMC_ADDR_CFG_HI);

  // storage; writes land at once whatever the mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 10; i++) begin
        mem_reg[i] <= (i == 0) ? CRMC_CONTROL_RST : CRMC_CFG_RST;
      end
    end else if (ce && wr_en && in_map) begin
      mem_reg[addr] <= wdata;
    end
  end

  // read data from a register; status page and unmapped reads decoded here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce && rd_en) begin
      rdata <= in_map ? mem_reg[addr] :
               (addr == CRMC_ADDR_STATUS) ? status : CRMC_UNMAPPED_RD;
    end
  end

  assign control = mem_reg[CRMC_ADDR_CONTROL];
  assign ie_mask = mem_reg[CRMC_ADDR_IE1];

endmodule : crmc_regfile

// ===== crmc_sync.sv
`timescale 1ns/1ps
module crmc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk, // system clock
  input  wire logic             rst,     // synchronous reset
  input  wire logic             ce,      // clock enable
  input  wire logic [WIDTH-1:0] d_async, // pin level
  output logic      [WIDTH-1:0] q_sync   // synchronised level
);

  logic [WIDTH-1:0] meta_reg;

  // two stages; only the second stage is read outside
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= '0;
      q_sync   <= '0;
    end else if (ce) begin
      meta_reg <= d_async;
      q_sync   <= meta_reg;
    end
  end

endmodule : crmc_sync

// ===== crmc_top.sv
`timescale 1ns/1ps
module crmc_top
  import crmc_pkg::*;
#(
  parameter int unsigned DUAL_SLOT    = 1,
  parameter int unsigned BREAK_CYCLES = CRMC_BREAK_CYCLES
) (
  input  wire logic                   sys_clk,     // 250 MHz system clock
  input  wire logic                   rst,         // synchronous reset, high
  input  wire logic                   ce,          // clock enable, freezes all state
  input  wire logic                   mode_pin,    // mode select line from processor
  input  wire logic                   i2c_sel_pin, // control-interface strap
  input  crmc_status_type             status_pin,  // raw status levels
  input  wire logic                   reg_wr,      // register write strobe
  input  wire logic                   reg_rd,      // register read strobe
  input  wire logic [CRMC_ADDR_W-1:0] reg_addr,    // register index
  input  wire logic [CRMC_DATA_W-1:0] reg_wdata,   // register write data
  output logic      [CRMC_DATA_W-1:0] reg_rdata,   // register read data
  output crmc_path_type               path,        // switch drive
  output logic                        sleeping,    // device asleep
  output logic                        reader_sel,  // 0 card 1, 1 card 2
  output logic                        cfg_apply,   // one-cycle deferred action
  output logic                        irq_event    // interrupt request level
);

  localparam int unsigned CNT_W = $clog2(BREAK_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(BREAK_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic            mode_sync;
  logic            i2c_sel_sync;
  crmc_status_type status_sync;

  // pins cross two flops before any logic looks at them
  crmc_sync #(
    .WIDTH (10)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .d_async ({mode_pin, i2c_sel_pin, status_pin}),
    .q_sync  ({mode_sync, i2c_sel_sync, status_sync})
  );

  // ---------------------------------------------------------------------------
  // control-interface strap
  // ---------------------------------------------------------------------------
  logic i2c_mode_reg;
  logic strap_done_reg;
  logic [1:0] strap_wait_reg;

  // captured once, after the synchroniser has filled; later changes ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      i2c_mode_reg   <= 1'b0;
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end else if (ce && !strap_done_reg) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      if (strap_wait_reg == 2'h2) begin
        i2c_mode_reg   <= i2c_sel_sync;
        strap_done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------------------
  logic [CRMC_DATA_W-1:0] control;
  logic [CRMC_DATA_W-1:0] ie_mask;

  // writes are refused under simple control and before the strap is known
  wire wr_ok  = reg_wr && i2c_mode_reg && strap_done_reg;
  wire cfg_wr = wr_ok && (reg_addr >= CRMC_ADDR_CFG_LO) &&
                (reg_addr <= CRMC_ADDR_CFG_HI);

  crmc_regfile u_regs (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (wr_ok),
    .rd_en   (reg_rd),
    .addr    (reg_addr),
    .wdata   (reg_wdata),
    .status  (status_sync),
    .rdata   (reg_rdata),
    .control (control),
    .ie_mask (ie_mask)
  );

  // ---------------------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------------------
  function automatic logic mode_active(input logic [1:0] m);
    mode_active = (m == CRMC_MODE_CARD1) || (m == CRMC_MODE_CARD2);
  endfunction : mode_active

  wire       ctl_wakeup = control[CRMC_BIT_WAKEUP];
  wire [1:0] ctl_mode   = control[CRMC_BIT_MODE_LO +: 2];
  wire [1:0] ctl_sw     = {control[CRMC_BIT_SD2SW], control[CRMC_BIT_SD1SW]};

  // second slot exists only on the two-port build
  wire       card2_ok   = (DUAL_SLOT != 0);
  wire [1:0] sw_allowed = {card2_ok, 1'b1};

  // simple control follows the line alone; I2C needs all three conditions
  wire sleep_now = i2c_mode_reg ?
                   (!ctl_wakeup || !mode_sync || !mode_active(ctl_mode)) :
                   !mode_sync;

  // a card 2 request on a one-slot build is treated like card 1
  wire target_sel = i2c_mode_reg && card2_ok &&
                    (ctl_mode == CRMC_MODE_CARD2);
  wire want_reader = strap_done_reg && !sleep_now;

  // ---------------------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------------------
  crmc_state_type   state_reg;
  crmc_state_type   state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             sel_reg;
  logic             sel_next;

  wire cnt_done = (cnt_reg == '0);

  // every transition passes through a break state with all affected paths open
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - CNT_W'(1);
    sel_next   = sel_reg;
    case (state_reg)
      CRMC_ST_PASS: begin
        if (want_reader) begin
          state_next = CRMC_ST_BREAK_IN;
          cnt_next   = CNT_LOAD;
          sel_next   = target_sel;
        end
      end
      CRMC_ST_BREAK_IN: begin
        if (cnt_done) begin
          if (want_reader && (target_sel == sel_reg)) begin
            state_next = CRMC_ST_READER;
          end else begin
            state_next = CRMC_ST_PASS;
          end
        end
      end
      CRMC_ST_READER: begin
        if (!want_reader || (target_sel != sel_reg)) begin
          state_next = CRMC_ST_BREAK_OUT;
          cnt_next   = CNT_LOAD;
        end
      end
      CRMC_ST_BREAK_OUT: begin
        if (cnt_done) begin
          state_next = CRMC_ST_PASS;
        end
      end
      default: begin
        state_next = CRMC_ST_PASS;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= CRMC_ST_PASS;
      cnt_reg   <= '0;
      sel_reg   <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sel_reg   <= sel_next;
    end
  end

  // ---------------------------------------------------------------------------
  // switch drive
  // ---------------------------------------------------------------------------
  crmc_path_type path_next;
  wire [1:0]     sel_onehot = sel_next ? 2'b10 : 2'b01;

  // in pass-through the switch bits act directly; in reader mode the chosen
  // card is taken from the host and the other slot keeps its own bit
  always_comb begin
    path_next                  = '0;
    path_next.mcu_on           = (state_next != CRMC_ST_PASS);
    path_next.host_close       = ctl_sw & sw_allowed;
    case (state_next)
      CRMC_ST_PASS: begin
        path_next.usb_host_close = 1'b1;
      end
      CRMC_ST_READER: begin
        path_next.host_close       = ctl_sw & sw_allowed & ~sel_onehot;
        path_next.reader_close     = sel_onehot;
        path_next.usb_reader_close = 1'b1;
      end
      CRMC_ST_BREAK_IN,
      CRMC_ST_BREAK_OUT: begin
        path_next.host_close = ctl_sw & sw_allowed & ~sel_onehot;
      end
      default: begin
        path_next = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // deferred configuration actions
  // ---------------------------------------------------------------------------
  logic pending_reg;

  // applied only on entry to reader mode; a write landing in the same cycle
  // keeps the flag set so it is not lost
  wire enter_reader = (state_reg == CRMC_ST_BREAK_IN) &&
                      (state_next == CRMC_ST_READER);
  wire apply_now    = enter_reader && pending_reg;
  wire pending_next = cfg_wr || (pending_reg && !apply_now);

  // ---------------------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------------------
  // I2C exposes every status bit through its enable; simple control only
  // reports card 1 detection, so the extra sources are I2C-only
  wire [CRMC_DATA_W-1:0] irq_src_i2c = status_sync & ie_mask;
  wire                   irq_now     = i2c_mode_reg ? (|irq_src_i2c) :
                                       status_sync.card1_det;

  // ---------------------------------------------------------------------------
  // output flops
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      path        <= '0;
      sleeping    <= 1'b1;
      reader_sel  <= 1'b0;
      cfg_apply   <= 1'b0;
      irq_event   <= 1'b0;
      pending_reg <= 1'b0;
    end else if (ce) begin
      path        <= path_next;
      sleeping    <= (state_next == CRMC_ST_PASS);
      reader_sel  <= sel_next;
      cfg_apply   <= apply_now;
      irq_event   <= irq_now;
      pending_reg <= pending_next;
    end
  end

endmodule : crmc_top

// ===== crmc_top_assertions.sv
`timescale 1ns/1ps
module crmc_top_assertions
  import crmc_pkg::*;
#(
  parameter int unsigned DUAL_SLOT    = 1,
  parameter int unsigned BREAK_CYCLES = CRMC_BREAK_CYCLES
) (
  input wire logic            sys_clk,     // clock
  input wire logic            rst,         // sync reset
  input wire logic            mode_pin,    // mode line
  input wire logic            i2c_sel_pin, // strap
  input wire crmc_status_type status_pin,  // raw status
  input wire crmc_path_type   path,        // switch drive
  input wire logic            sleeping,    // asleep
  input wire logic            reader_sel,  // reader card
  input wire logic            cfg_apply,   // deferred pulse
  input wire logic            irq_event    // interrupt
);
  // ---------------------------------------------------------------------------
  // bound: two syncs, both break windows, slack
  // ---------------------------------------------------------------------------
  localparam int SETTLE = 4 * BREAK_CYCLES + 12;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reader_no_host: assert property (
    path.usb_reader_close |-> !path.usb_host_close && (path.reader_close & path.host_close) == 2'h0)
    else $error("reader and host share a path");
  a_card_path: assert property (
    path.usb_reader_close |-> path.reader_close == (reader_sel ? 2'h2 : 2'h1))
    else $error("reader switch does not match card");
  a_break_enter: assert property (
    $rose(path.usb_reader_close) |-> !$past(path.usb_host_close, 2))
    else $error("reader closed without a break");
  a_break_leave: assert property (
    $rose(path.usb_host_close) |-> !$past(path.usb_reader_close))
    else $error("host closed without a break");
  a_sleep_no_reader: assert property (
    sleeping |-> !path.mcu_on && path.reader_close == 2'h0 && !path.usb_reader_close)
    else $error("asleep but reader side active");
  a_pass_host_usb: assert property (
    sleeping && $past(sleeping) && !$past(rst) |-> path.usb_host_close)
    else $error("pass-through lost host usb");
  a_simple_one_card: assert property (
    !i2c_sel_pin |-> !reader_sel)
    else $error("simple control picked card two");
  a_mode_low_sleeps: assert property (
    $fell(mode_pin) |-> ##[1:SETTLE] sleeping)
    else $error("mode low did not sleep");
  a_simple_reader: assert property (
    $rose(mode_pin) && !i2c_sel_pin |-> ##[1:SETTLE] path.usb_reader_close)
    else $error("mode high did not start reader");
  a_apply_pulse: assert property (
    cfg_apply |-> path.usb_reader_close ##1 !cfg_apply)
    else $error("deferred action outside reader entry");
  a_simple_irq: assert property (
    $rose(status_pin.card1_det) && !i2c_sel_pin |-> ##[1:5] irq_event)
    else $error("card detect raised no interrupt");
endmodule : crmc_top_assertions
